// ---- rtl/ris_pkg.sv ----
// Purpose: constants for the remappable input select block
// Assumes: 16-bit selector registers, one per aligned 32-bit bus word
// Notes:   selector index 0 is irq4, then timer 2..5, capture 1..8, fault a/b
package ris_pkg;
    localparam int          SEL_W       = 6;
    localparam int          NUM_SEL     = 15;
    localparam int          NUM_PINS    = 64;
    localparam int          ADDR_W      = 6;
    localparam int          DATA_W      = 32;
    localparam int          IDX_W       = 4;
    // register byte offsets
    localparam logic [5:0]  OFS_EXT_IRQ4        = 6'h00;
    localparam logic [5:0]  OFS_TIMER3_TIMER2   = 6'h04;
    localparam logic [5:0]  OFS_TIMER5_TIMER4   = 6'h08;
    localparam logic [5:0]  OFS_CAPTURE_TWO_ONE = 6'h0c;
    localparam logic [5:0]  OFS_CAPTURE_FOUR_THREE = 6'h10;
    localparam logic [5:0]  OFS_CAPTURE_SIX_FIVE   = 6'h14;
    localparam logic [5:0]  OFS_CAPTURE_EIGHT_SEVEN = 6'h18;
    localparam logic [5:0]  OFS_COMPARE_FAULT   = 6'h1c;
    localparam logic [5:0]  OFS_LOCAL_LOCK      = 6'h20;
    localparam logic [3:0]  LAST_SEL_REG_IDX    = 4'h7;
    // field positions
    localparam int          LO_LSB      = 0;
    localparam int          HI_LSB      = 8;
    localparam int          LOCK_BIT    = 0;
    // reset and special values
    localparam logic [5:0]  SEL_RESET   = 6'h3f;
    localparam logic [5:0]  GROUND_PIN  = 6'h3f;
    localparam logic        LOCK_RESET  = 1'b0;
    // selector slots
    localparam int IDX_EXT_IRQ4   = 0;
    localparam int IDX_TIMER2     = 1;
    localparam int IDX_TIMER3     = 2;
    localparam int IDX_TIMER4     = 3;
    localparam int IDX_TIMER5     = 4;
    localparam int IDX_CAPTURE1   = 5;
    localparam int IDX_FAULT_A    = 13;
    localparam int IDX_FAULT_B    = 14;

    // low-half selector slot of paired register idx (1..7)
    function automatic logic [3:0] ris_lo_slot(input logic [3:0] idx);
        return 4'({idx, 1'b0} - 5'h01);
    endfunction

    // high-half selector slot of paired register idx (1..7)
    function automatic logic [3:0] ris_hi_slot(input logic [3:0] idx);
        return 4'({idx, 1'b0});
    endfunction
endpackage

// ---- rtl/ris_regfile.sv ----
// Purpose: holds the fifteen 6-bit source selectors
// Assumes: write requests are already gated by the lock
// Notes:   byte lane 0 carries the low selector, lane 1 the high one
`timescale 1ns/1ps
`default_nettype none
module ris_regfile (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    ris_sel_if.store  sif
);
    typedef struct packed {
        logic [ris_pkg::NUM_SEL-1:0][ris_pkg::SEL_W-1:0] sel;
    } ris_rf_state_t;

    ris_rf_state_t st;
    ris_rf_state_t next_st;

    // field update from a granted write
    always_comb begin
        next_st = st;
        if (sif.wr_en) begin
            if (sif.wr_idx == 4'h0) begin
                if (sif.wr_be[0]) begin
                    next_st.sel[ris_pkg::IDX_EXT_IRQ4] =
                        sif.wr_data[ris_pkg::LO_LSB +: ris_pkg::SEL_W];
                end
            end else begin
                if (sif.wr_be[0]) begin
                    next_st.sel[ris_pkg::ris_lo_slot(sif.wr_idx)] =
                        sif.wr_data[ris_pkg::LO_LSB +: ris_pkg::SEL_W];
                end
                if (sif.wr_be[1]) begin
                    next_st.sel[ris_pkg::ris_hi_slot(sif.wr_idx)] =
                        sif.wr_data[ris_pkg::HI_LSB +: ris_pkg::SEL_W];
                end
            end
        end
    end

    // state register, all selectors reset to the ground code
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st.sel <= {ris_pkg::NUM_SEL{ris_pkg::SEL_RESET}};
        end else begin
            st <= next_st;
        end
    end

    assign sif.sel = st.sel;
endmodule
`default_nettype wire

// ---- rtl/ris_route.sv ----
// Purpose: steers one remappable pin onto each peripheral input
// Assumes: pins are synchronous to clk_i
// Notes:   outputs are registered, one cycle behind pins and selectors
`timescale 1ns/1ps
`default_nettype none
module ris_route #(
    parameter logic [ris_pkg::NUM_PINS-1:0] PIN_IMPL_MASK = {64{1'b1}}
) (
    input  wire logic                         clk_i,
    input  wire logic                         rstn_i,
    input  wire logic [ris_pkg::NUM_PINS-1:0] pin_i,
    ris_sel_if.route                          sif,
    output logic      [ris_pkg::NUM_SEL-1:0]  periph_o
);
    typedef struct packed {
        logic [ris_pkg::NUM_SEL-1:0] periph;
    } ris_rt_state_t;

    ris_rt_state_t st;
    ris_rt_state_t next_st;

    // per-input multiplexer with ground and missing-pin cases
    always_comb begin
        next_st = st;
        for (int i = 0; i < ris_pkg::NUM_SEL; i++) begin
            if (sif.sel[i] == ris_pkg::GROUND_PIN) begin
                next_st.periph[i] = 1'b0;
            end else if (!PIN_IMPL_MASK[sif.sel[i]]) begin
                next_st.periph[i] = 1'b0;
            end else begin
                next_st.periph[i] = pin_i[sif.sel[i]];
            end
        end
    end

    // output register
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st.periph <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign periph_o = st.periph;
endmodule
`default_nettype wire

// ---- rtl/ris_sel_if.sv ----
// Purpose: carries selector values and write requests between submodules
// Assumes: one clock domain
// Notes:   sel is the stored state of all fifteen selectors
`timescale 1ns/1ps
`default_nettype none
interface ris_sel_if;
    logic                                       wr_en;
    logic [ris_pkg::IDX_W-1:0]                  wr_idx;
    logic [15:0]                                wr_data;
    logic [1:0]                                 wr_be;
    logic [ris_pkg::NUM_SEL-1:0][ris_pkg::SEL_W-1:0] sel;

    modport ctrl  (output wr_en, output wr_idx, output wr_data,
                   output wr_be, input sel);
    modport store (input wr_en, input wr_idx, input wr_data,
                   input wr_be, output sel);
    modport route (input sel);
endinterface
`default_nettype wire

// ---- rtl/ris_top.sv ----
// Purpose: avalon-mm slave for the input select registers plus routing
// Assumes: one clock; external lock level synchronous to clk_i
// Notes:   every access takes one wait cycle, then completes
`timescale 1ns/1ps
`default_nettype none
module ris_top #(
    parameter logic [ris_pkg::NUM_PINS-1:0] PIN_IMPL_MASK = {64{1'b1}}
) (
    input  wire logic                          clk_i,
    input  wire logic                          rstn_i,
    input  wire logic [ris_pkg::ADDR_W-1:0]    avs_address_i,
    input  wire logic                          avs_read_i,
    input  wire logic                          avs_write_i,
    input  wire logic [ris_pkg::DATA_W-1:0]    avs_writedata_i,
    input  wire logic [3:0]                    avs_byteenable_i,
    output logic      [ris_pkg::DATA_W-1:0]    avs_readdata_o,
    output logic                               avs_waitrequest_o,
    input  wire logic                          pin_config_lock_i,
    input  wire logic [ris_pkg::NUM_PINS-1:0]  remappable_pin_i,
    output logic      [ris_pkg::NUM_SEL-1:0]   peripheral_input_o,
    output logic                               pin_config_lock_o
);
    typedef struct packed {
        logic                          waitreq;
        logic [ris_pkg::DATA_W-1:0]    rdata;
        logic                          lock;
        logic                          lock_out;
    } ris_top_state_t;

    ris_top_state_t st;
    ris_top_state_t next_st;
    ris_sel_if      sif ();

    logic                      req;
    logic                      accept;
    logic                      lock_eff;
    logic [ris_pkg::IDX_W-1:0] idx;

    assign req      = avs_read_i | avs_write_i;
    assign accept   = req & ~st.waitreq;
    assign lock_eff = pin_config_lock_i | st.lock;
    assign idx      = avs_address_i[ris_pkg::ADDR_W-1:2];

    // read word assembly; unmapped words and empty bits read zero
    function automatic logic [31:0] read_word(
        input logic [3:0] ridx,
        input logic [ris_pkg::NUM_SEL-1:0][ris_pkg::SEL_W-1:0] s,
        input logic lk
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        if (ridx == 4'h0) begin
            w[ris_pkg::LO_LSB +: ris_pkg::SEL_W] =
                s[ris_pkg::IDX_EXT_IRQ4];
        end else if (ridx <= ris_pkg::LAST_SEL_REG_IDX) begin
            w[ris_pkg::LO_LSB +: ris_pkg::SEL_W] =
                s[ris_pkg::ris_lo_slot(ridx)];
            w[ris_pkg::HI_LSB +: ris_pkg::SEL_W] =
                s[ris_pkg::ris_hi_slot(ridx)];
        end else if (ridx == ris_pkg::OFS_LOCAL_LOCK[5:2]) begin
            w[ris_pkg::LOCK_BIT] = lk;
        end
        return w;
    endfunction

    // bus handshake, lock register and gated selector writes
    always_comb begin
        next_st          = st;
        next_st.lock_out = lock_eff;
        sif.wr_en        = 1'b0;
        sif.wr_idx       = idx;
        sif.wr_data      = avs_writedata_i[15:0];
        sif.wr_be        = avs_byteenable_i[1:0];
        if (req && st.waitreq) begin
            next_st.waitreq = 1'b0;
            next_st.rdata   = read_word(idx, sif.sel, st.lock);
        end else begin
            next_st.waitreq = 1'b1;
        end
        if (accept && avs_write_i) begin
            if (avs_address_i == ris_pkg::OFS_LOCAL_LOCK) begin
                if (avs_byteenable_i[0]) begin
                    next_st.lock = avs_writedata_i[ris_pkg::LOCK_BIT];
                end
            end else if (idx <= ris_pkg::LAST_SEL_REG_IDX) begin
                sif.wr_en = ~lock_eff;
            end
        end
    end

    // state register; local lock starts unlocked
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st.waitreq  <= 1'b1;
            st.rdata    <= 32'h0000_0000;
            st.lock     <= ris_pkg::LOCK_RESET;
            st.lock_out <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // selector storage
    ris_regfile u_regfile (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .sif    (sif)
    );

    // pin routing
    ris_route #(
        .PIN_IMPL_MASK (PIN_IMPL_MASK)
    ) u_route (
        .clk_i    (clk_i),
        .rstn_i   (rstn_i),
        .pin_i    (remappable_pin_i),
        .sif      (sif),
        .periph_o (peripheral_input_o)
    );

    assign avs_readdata_o    = st.rdata;
    assign avs_waitrequest_o = st.waitreq;
    assign pin_config_lock_o = st.lock_out;
endmodule
`default_nettype wire

// ---- sim/ris_chk.sv ----
// Purpose: port-level checks of the input select block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound into ris_top
`timescale 1ns/1ps
`default_nettype none
module ris_chk (
    input wire logic        clk_i,
    input wire logic        rstn_i,
    input wire logic [5:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        pin_config_lock_i,
    input wire logic [14:0] peripheral_input_o,
    input wire logic        pin_config_lock_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // bus answers after exactly one wait cycle and frees at once
    wait_one_a: assert property ((avs_read_i || avs_write_i)
        && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
    wait_short_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    read_hold_a: assert property (avs_waitrequest_o |-> $stable(avs_readdata_o))
        else $error("read data moved between accesses");
    // unused bit positions read zero
    pair_pad_a: assert property (avs_read_i && !avs_waitrequest_o |->
        avs_readdata_o[31:14] == '0 && avs_readdata_o[7:6] == '0)
        else $error("pad bits not zero");
    irq_pad_a: assert property (avs_read_i && !avs_waitrequest_o
        && avs_address_i[5:2] == 4'h0 |-> avs_readdata_o[31:6] == '0)
        else $error("irq4 pad bits not zero");
    // lock follows the external level and starts unlocked
    lock_follow_a: assert property (pin_config_lock_i |=> pin_config_lock_o)
        else $error("lock not effective");
    // the lock output after release comes from the reset value of the lock
    reset_unlock_a: assert property ($rose(rstn_i) && !pin_config_lock_i
        |=> !pin_config_lock_o) else $error("locked after reset");
    // two edges on, the route is built from the reset selectors, not reset
    reset_ground_a: assert property ($rose(rstn_i) |-> ##2
        peripheral_input_o == '0) else $error("inputs not grounded");
    wr_done_c: cover property (avs_write_i && !avs_waitrequest_o);
    rd_done_c: cover property (avs_read_i && !avs_waitrequest_o);
    locked_c: cover property (pin_config_lock_o);
    routed_c: cover property (peripheral_input_o != '0);
endmodule
bind ris_top ris_chk ris_chk_i (.*);
`default_nettype wire

// ---- sim/ris_pad_model.sv ----
// Purpose: pads feeding the remappable pins
// Assumes: pad levels are synchronous to the core clock
// Notes:   levels settle one edge after the bench asks
`timescale 1ns/1ps
`default_nettype none
module ris_pad_model (
    input  wire logic        clk_i,
    input  wire logic [63:0] level_i,
    output logic      [63:0] pin_o
);
    // pads change only on the rising edge
    always_ff @(posedge clk_i) begin
        pin_o <= level_i;
    end
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// Purpose: self-checking bench for the input select block
// Assumes: one wait cycle per bus access
// Notes:   pin 20 is left out of the pin mask
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct {logic [5:0] a; logic [31:0] d; logic [31:0] e;} ris_row_t;
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [5:0]  adr = '0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdat = '0;
    logic        lock_in = 1'b0;
    logic [63:0] level = '0;
    logic [63:0] pins;
    logic [31:0] rdat;
    logic        wreq;
    logic [14:0] periph;
    logic        lock_out;
    logic [31:0] q;
    int          failures = 0;
    int          n_tests = 0;
    int          cyc = 0;
    ris_row_t    rows [9] = '{
        '{6'h00, 32'hffff_ffc5, 32'h0000_0005},
        '{6'h04, 32'hffff_c1c2, 32'h0000_0102},
        '{6'h08, 32'hffff_c3c4, 32'h0000_0304},
        '{6'h0c, 32'hffff_c6c7, 32'h0000_0607},
        '{6'h10, 32'h0000_0809, 32'h0000_0809},
        '{6'h14, 32'h0000_0a0b, 32'h0000_0a0b},
        '{6'h18, 32'h0000_0c0d, 32'h0000_0c0d},
        '{6'h1c, 32'h0000_0e0f, 32'h0000_0e0f},
        '{6'h24, 32'hffff_ffff, 32'h0000_0000}};
    // pin each peripheral input should follow after the row writes
    logic [5:0]  route [15] = '{6'h05, 6'h02, 6'h01, 6'h04, 6'h03, 6'h07,
        6'h06, 6'h09, 6'h08, 6'h0b, 6'h0a, 6'h0d, 6'h0c, 6'h0f, 6'h0e};
    logic [5:0]  msel [3] = '{6'h14, 6'h15, 6'h3f};
    logic        mexp [3] = '{1'b0, 1'b1, 1'b0};

    initial forever #4 clk_i = ~clk_i;

    ris_pad_model ris_pad_model_i (.clk_i(clk_i), .level_i(level), .pin_o(pins));
    ris_top #(.PIN_IMPL_MASK(64'hffff_ffff_ffef_ffff)) ris_top_i (
        .clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .pin_config_lock_i(lock_in),
        .remappable_pin_i(pins), .peripheral_input_o(periph),
        .pin_config_lock_o(lock_out));

    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr <= w;
        rd <= !w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (wreq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // cuts a hang short
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            complete_run();
        end
    end

    // main sequence
    initial begin
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        level <= '1;
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 6'(4 * i), '0);
            check(q, i == 0 ? 32'h0000_003f : 32'h0000_3f3f);
        end
        check(32'(periph), '0);
        check(32'(lock_out), '0);
        $display("reset test end");
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].d);
            bus(1'b0, rows[i].a, '0);
            check(q, rows[i].e);
        end
        $display("register test end");
        foreach (route[i]) begin
            level <= 64'h1 << route[i];
            repeat (3) @(posedge clk_i);
            check(32'(periph), 32'h1 << i);
        end
        $display("route test end");
        lock_in <= 1'b1;
        bus(1'b1, 6'h00, 32'h0000_0001);
        bus(1'b0, 6'h00, '0);
        check(q, 32'h0000_0005);
        lock_in <= 1'b0;
        bus(1'b1, 6'h20, 32'h0000_0001);
        // local lock lands at the completion edge, its output one edge later
        repeat (2) @(posedge clk_i);
        check(32'(lock_out), 32'h1);
        bus(1'b1, 6'h04, '0);
        bus(1'b0, 6'h04, '0);
        check(q, 32'h0000_0102);
        bus(1'b1, 6'h20, '0);
        $display("lock test end");
        level <= '1;
        foreach (msel[i]) begin
            bus(1'b1, 6'h00, 32'(msel[i]));
            repeat (3) @(posedge clk_i);
            check(32'(periph[0]), 32'(mexp[i]));
        end
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        bus(1'b0, 6'h04, '0);
        check(q, 32'h0000_3f3f);
        $display("mask and reset test end");
        complete_run();
    end
endmodule
`default_nettype wire
